// ==== rtl/pcmt_pkg.sv ====
package pcmt_pkg;
  // coefficient fixed point: signed, 12 fraction bits
  localparam int COEF_W = 28;
  localparam int FRAC_W = 12;
  localparam int NUM_COEF = 12;
  localparam logic [COEF_W-1:0] COEF_UNITY = 28'h0001000;
  localparam logic [COEF_W-1:0] COEF_MAX = 28'h7ffffff;
  // preset matrices: diagonal boost per preset step, rows sum to unity
  localparam logic [COEF_W-1:0] PRESET_STEP = 28'h00000c0;
  // white balance ratios, 12 fraction bits
  localparam int WB_W = 16;
  localparam logic [WB_W-1:0] WB_RED_BASE = 16'h1c00;
  localparam logic [WB_W-1:0] WB_BLUE_BASE = 16'h1200;
  localparam logic [WB_W-1:0] WB_STEP = 16'h0100;
  localparam logic [WB_W-1:0] WB_RESET = 16'h1000;
  // vividness level, 8 fraction bits
  localparam int SAT_W = 12;
  localparam int SAT_FRAC = 8;
  localparam logic [SAT_W-1:0] SAT_UNITY = 12'h100;
  // luma/chroma gains, rows Y, U, V
  localparam logic [9*COEF_W-1:0] YUV_GAINS = {
    28'hffffeb4, 28'hffff94c, 28'h0000800,
    28'h0000800, 28'hffffab4, 28'hffffd4c,
    28'h00001d3, 28'h0000964, 28'h00004c9};
  localparam logic [3:0] IDX_FIRST_OFFSET = 4'h9;
  localparam logic [3:0] IDX_LAST = 4'hb;

  typedef enum logic {XF_NATIVE_TO_SRGB, XF_LUMA_CHROMA} pcmt_xform_e;
  typedef enum logic [2:0] {ILL_GENERAL, ILL_INCANDESCENT, ILL_WARM_FLUOR, ILL_COOL_FLUOR,
                            ILL_DAYLIGHT, ILL_CLOUDY, ILL_SHADED_DAYLIGHT, ILL_CUSTOM} pcmt_illum_e;

  // preset gain k (row*3+col) for preset p
  function automatic logic [COEF_W-1:0] pcmt_preset_gain(input logic [2:0] p, input logic [3:0] k);
    logic [COEF_W-1:0] boost;
    boost = COEF_W'(COEF_W'(p) * PRESET_STEP);
    if (k > 4'h8) return '0;
    if (k[1:0] == 2'b00) return COEF_UNITY + boost;
    return '0 - (boost >> 1);
  endfunction : pcmt_preset_gain

  // signed fixed point to single precision float
  function automatic logic [31:0] pcmt_fix_to_float(input logic [COEF_W-1:0] v);
    logic [COEF_W-1:0] mag;
    logic [COEF_W-1:0] norm;
    logic [31:0] res;
    int p;
    mag = v[COEF_W-1] ? (~v + 1'b1) : v;
    p = -1;
    res = '0;
    for (int i = 0; i < COEF_W; i++) begin
      if (mag[i]) p = i;
    end
    if (p >= 0) begin
      norm = (p > 23) ? (mag >> (p - 23)) : (mag << (23 - p));
      res[31] = v[COEF_W-1];
      res[30:23] = 8'(p - FRAC_W + 127);
      res[22:0] = norm[22:0];
    end
    return res;
  endfunction : pcmt_fix_to_float

  // single precision float to signed fixed point, saturating
  function automatic logic [COEF_W-1:0] pcmt_float_to_fix(input logic [31:0] f);
    logic [COEF_W-1:0] mant;
    logic [COEF_W-1:0] mag;
    int sh;
    mant = COEF_W'({1'b1, f[22:0]});
    sh = int'(f[30:23]) - 150 + FRAC_W;
    if (f[30:23] == 8'h00 || sh < -24) mag = '0;
    else if (sh > COEF_W - 25) mag = COEF_MAX;
    else if (sh >= 0) mag = mant << sh;
    else mag = mant >> (-sh);
    return f[31] ? (~mag + 1'b1) : mag;
  endfunction : pcmt_float_to_fix
endpackage : pcmt_pkg

// ==== rtl/pcmt_matrix.sv ====
`timescale 1ns/1ps
// 3x3 matrix plus offset on one pixel, one cycle latency, clamped
module pcmt_matrix import pcmt_pkg::*; #(
  parameter int PIX_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pixel in
  input wire logic in_valid,
  input wire logic [PIX_W-1:0] in_r,
  input wire logic [PIX_W-1:0] in_g,
  input wire logic [PIX_W-1:0] in_b,
  // coefficients: nine gains then three offsets
  input wire logic [NUM_COEF*COEF_W-1:0] coefs,
  input wire logic pass,
  // pixel out
  output logic out_valid,
  output logic [PIX_W-1:0] out_c0,
  output logic [PIX_W-1:0] out_c1,
  output logic [PIX_W-1:0] out_c2
);
  localparam int ACC_W = COEF_W + PIX_W + 4;

  logic [PIX_W-1:0] pix [3];
  logic [PIX_W-1:0] chan_d [3];
  logic [PIX_W-1:0] chan_q [3];
  logic valid_q;

  function automatic logic [PIX_W-1:0] clamp_pix(input logic signed [ACC_W-1:0] v);
    if (v < 0) return '0;
    if (v > $signed(ACC_W'({PIX_W{1'b1}}))) return '1;
    return PIX_W'(v);
  endfunction : clamp_pix

  assign pix[0] = in_r;
  assign pix[1] = in_g;
  assign pix[2] = in_b;

  // row sums of products plus offset
  always_comb begin
    logic signed [ACC_W-1:0] acc;
    acc = '0;
    for (int row = 0; row < 3; row++) begin
      acc = ACC_W'($signed(coefs[(9 + row)*COEF_W +: COEF_W]));
      for (int col = 0; col < 3; col++) begin
        acc = acc + ACC_W'($signed(coefs[(row*3 + col)*COEF_W +: COEF_W])) *
              ACC_W'($signed({1'b0, pix[col]}));
      end
      chan_d[row] = pass ? pix[row] : clamp_pix(acc >>> FRAC_W);
    end
  end

  // output registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_q <= 1'b0;
      for (int i = 0; i < 3; i++) chan_q[i] <= '0;
    end else begin
      valid_q <= in_valid;
      for (int i = 0; i < 3; i++) chan_q[i] <= chan_d[i];
    end
  end

  assign out_valid = valid_q;
  assign out_c0 = chan_q[0];
  assign out_c1 = chan_q[1];
  assign out_c2 = chan_q[2];
endmodule : pcmt_matrix

// ==== rtl/pcmt_saturate.sv ====
`timescale 1ns/1ps
// vividness adjust: scales each channel's distance from luma, one cycle
module pcmt_saturate import pcmt_pkg::*; #(
  parameter int PIX_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic on,
  input wire logic [SAT_W-1:0] level,
  // pixel in
  input wire logic in_valid,
  input wire logic [PIX_W-1:0] in_r,
  input wire logic [PIX_W-1:0] in_g,
  input wire logic [PIX_W-1:0] in_b,
  // pixel out
  output logic out_valid,
  output logic [PIX_W-1:0] out_r,
  output logic [PIX_W-1:0] out_g,
  output logic [PIX_W-1:0] out_b
);
  localparam int W = PIX_W + SAT_W + 4;

  logic [PIX_W-1:0] pix [3];
  logic [PIX_W-1:0] chan_d [3];
  logic [PIX_W-1:0] chan_q [3];
  logic valid_q;

  assign pix[0] = in_r;
  assign pix[1] = in_g;
  assign pix[2] = in_b;

  // luma + (c - luma) * level; level above unity widens colour spread
  always_comb begin
    logic signed [W-1:0] luma;
    logic signed [W-1:0] v;
    v = '0;
    luma = W'(({2'b00, in_r} + {1'b0, in_g, 1'b0} + {2'b00, in_b}) >> 2);
    for (int i = 0; i < 3; i++) begin
      v = luma + ((W'($signed({1'b0, pix[i]})) - luma) * W'($signed({1'b0, level})) >>> SAT_FRAC);
      if (!on) chan_d[i] = pix[i];
      else if (v < 0) chan_d[i] = '0;
      else if (v > $signed(W'({PIX_W{1'b1}}))) chan_d[i] = '1;
      else chan_d[i] = PIX_W'(v);
    end
  end

  // output registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_q <= 1'b0;
      for (int i = 0; i < 3; i++) chan_q[i] <= '0;
    end else begin
      valid_q <= in_valid;
      for (int i = 0; i < 3; i++) chan_q[i] <= chan_d[i];
    end
  end

  assign out_valid = valid_q;
  assign out_r = chan_q[0];
  assign out_g = chan_q[1];
  assign out_b = chan_q[2];
endmodule : pcmt_saturate

// ==== rtl/pcmt_top.sv ====
`timescale 1ns/1ps
// colour transform path: correction, vividness, then gamma outside, then luma/chroma
module pcmt_top import pcmt_pkg::*; #(
  parameter int PIX_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // native rgb pixels in
  input wire logic pix_valid,
  input wire logic [PIX_W-1:0] pix_r,
  input wire logic [PIX_W-1:0] pix_g,
  input wire logic [PIX_W-1:0] pix_b,
  // corrected linear pixels to the gamma stage
  output logic lin_valid,
  output logic [PIX_W-1:0] lin_r,
  output logic [PIX_W-1:0] lin_g,
  output logic [PIX_W-1:0] lin_b,
  // gamma-corrected pixels back
  input wire logic gam_valid,
  input wire logic [PIX_W-1:0] gam_r,
  input wire logic [PIX_W-1:0] gam_g,
  input wire logic [PIX_W-1:0] gam_b,
  // final pixels
  output logic out_valid,
  output logic [PIX_W-1:0] out_c0,
  output logic [PIX_W-1:0] out_c1,
  output logic [PIX_W-1:0] out_c2,
  // pipeline and format state
  input wire logic image_pipeline_enable,
  input wire logic yuv_format_active,
  // transform instance controls
  input wire logic transform_instance_select,
  input wire logic transform_on_wr,
  input wire logic transform_on_wdata,
  output logic transform_instance_on,
  // coefficient access
  input wire logic [3:0] coefficient_index_select,
  input wire logic coefficient_wr,
  input wire logic [31:0] coefficient_wdata,
  output logic [31:0] coefficient_value,
  // illuminant preset
  input wire logic preset_wr,
  input wire logic [2:0] illuminant_preset_select,
  output logic [2:0] illuminant_preset,
  // white balance ratios
  input wire logic wb_red_wr,
  input wire logic wb_blue_wr,
  input wire logic [WB_W-1:0] wb_ratio_wdata,
  output logic [WB_W-1:0] white_balance_red_ratio,
  output logic [WB_W-1:0] white_balance_blue_ratio,
  // vividness
  input wire logic vividness_adjust_on,
  input wire logic [SAT_W-1:0] vividness_level
);
  logic rgb_on_q;
  logic rgb_on_d;
  pcmt_illum_e illum_q;
  pcmt_illum_e illum_d;
  logic [NUM_COEF-1:0][COEF_W-1:0] custom_q;
  logic [NUM_COEF-1:0][COEF_W-1:0] custom_d;
  logic [NUM_COEF-1:0][COEF_W-1:0] ccm_coefs;
  logic [NUM_COEF-1:0][COEF_W-1:0] yuv_coefs;
  logic [WB_W-1:0] wb_red_q;
  logic [WB_W-1:0] wb_red_d;
  logic [WB_W-1:0] wb_blue_q;
  logic [WB_W-1:0] wb_blue_d;
  logic [31:0] value_q;
  logic [31:0] value_d;
  logic on_read_q;
  logic on_read_d;
  logic sel_yuv;
  logic idx_ok;
  logic ccm_valid;
  logic [PIX_W-1:0] ccm_r;
  logic [PIX_W-1:0] ccm_g;
  logic [PIX_W-1:0] ccm_b;

  assign sel_yuv = (transform_instance_select == XF_LUMA_CHROMA);
  assign idx_ok = (coefficient_index_select <= IDX_LAST);

  // coefficient set in use for the correction
  always_comb begin
    for (int k = 0; k < NUM_COEF; k++) begin
      if (illum_q == ILL_CUSTOM) ccm_coefs[k] = custom_q[k];
      else ccm_coefs[k] = pcmt_preset_gain(illum_q, 4'(k));
    end
  end

  // fixed luma/chroma set: chroma offsets sit at mid scale
  always_comb begin
    for (int k = 0; k < 9; k++) yuv_coefs[k] = YUV_GAINS[k*COEF_W +: COEF_W];
    yuv_coefs[9] = '0;
    yuv_coefs[10] = COEF_W'(64'd1 << (PIX_W - 1 + FRAC_W));
    yuv_coefs[11] = COEF_W'(64'd1 << (PIX_W - 1 + FRAC_W));
  end

  // control next state
  always_comb begin
    rgb_on_d = rgb_on_q;
    illum_d = illum_q;
    custom_d = custom_q;
    wb_red_d = wb_red_q;
    wb_blue_d = wb_blue_q;
    if (image_pipeline_enable) begin
      if (transform_on_wr && !sel_yuv) rgb_on_d = transform_on_wdata;
      if (coefficient_wr && !sel_yuv && idx_ok && illum_q == ILL_CUSTOM) begin
        custom_d[coefficient_index_select] = pcmt_float_to_fix(coefficient_wdata);
      end
      if (preset_wr) begin
        illum_d = pcmt_illum_e'(illuminant_preset_select);
        if (illuminant_preset_select != ILL_CUSTOM) begin
          wb_red_d = WB_RED_BASE - WB_W'(WB_W'(illuminant_preset_select) * WB_STEP);
          wb_blue_d = WB_BLUE_BASE + WB_W'(WB_W'(illuminant_preset_select) * WB_STEP);
        end
      end
    end
    // manual or automatic balance overrides a preset load in the same cycle
    if (wb_red_wr) wb_red_d = wb_ratio_wdata;
    if (wb_blue_wr) wb_blue_d = wb_ratio_wdata;
  end

  // readback next state
  always_comb begin
    value_d = '0;
    on_read_d = 1'b0;
    if (image_pipeline_enable) begin
      on_read_d = sel_yuv ? yuv_format_active : rgb_on_q;
      if (idx_ok) begin
        value_d = pcmt_fix_to_float(sel_yuv ? yuv_coefs[coefficient_index_select] :
                                    ccm_coefs[coefficient_index_select]);
      end
    end
  end

  // control and readback registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rgb_on_q <= 1'b1;
      illum_q <= ILL_GENERAL;
      for (int k = 0; k < NUM_COEF; k++) custom_q[k] <= (k < 9 && k % 4 == 0) ? COEF_UNITY : '0;
      wb_red_q <= WB_RESET;
      wb_blue_q <= WB_RESET;
      value_q <= '0;
      on_read_q <= 1'b0;
    end else begin
      rgb_on_q <= rgb_on_d;
      illum_q <= illum_d;
      custom_q <= custom_d;
      wb_red_q <= wb_red_d;
      wb_blue_q <= wb_blue_d;
      value_q <= value_d;
      on_read_q <= on_read_d;
    end
  end

  assign transform_instance_on = on_read_q;
  assign coefficient_value = value_q;
  assign illuminant_preset = illum_q;
  assign white_balance_red_ratio = wb_red_q;
  assign white_balance_blue_ratio = wb_blue_q;

  // native to srgb correction
  pcmt_matrix #(.PIX_W(PIX_W)) u_correction (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(pix_valid),
    .in_r(pix_r),
    .in_g(pix_g),
    .in_b(pix_b),
    .coefs(ccm_coefs),
    .pass(!rgb_on_q),
    .out_valid(ccm_valid),
    .out_c0(ccm_r),
    .out_c1(ccm_g),
    .out_c2(ccm_b)
  );

  // vividness adjust after correction, before gamma
  pcmt_saturate #(.PIX_W(PIX_W)) u_vivid (
    .clk(clk),
    .rst_n(rst_n),
    .on(vividness_adjust_on),
    .level(vividness_level),
    .in_valid(ccm_valid),
    .in_r(ccm_r),
    .in_g(ccm_g),
    .in_b(ccm_b),
    .out_valid(lin_valid),
    .out_r(lin_r),
    .out_g(lin_g),
    .out_b(lin_b)
  );

  // luma/chroma conversion on gamma output, only for yuv formats
  pcmt_matrix #(.PIX_W(PIX_W)) u_luma_chroma (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(gam_valid),
    .in_r(gam_r),
    .in_g(gam_g),
    .in_b(gam_b),
    .coefs(yuv_coefs),
    .pass(!yuv_format_active),
    .out_valid(out_valid),
    .out_c0(out_c0),
    .out_c1(out_c1),
    .out_c2(out_c2)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // correction write takes effect
  rgb_on_write_a: assert property (image_pipeline_enable && transform_on_wr && !sel_yuv |=>
    rgb_on_q == $past(transform_on_wdata) ##1 transform_instance_on == ($past(image_pipeline_enable) &&
    ($past(sel_yuv) ? $past(yuv_format_active) : $past(rgb_on_q)))) else $error("correction enable write lost");

  // conversion enable is read-only
  yuv_read_only_a: assert property (transform_on_wr && sel_yuv |=> $stable(rgb_on_q))
    else $error("conversion select changed correction enable");

  // correction enable, custom coefficients and preset hold while the pipeline is off; coefficient readback is zero
  gated_access_a: assert property (!image_pipeline_enable |=> $stable(rgb_on_q) && $stable(custom_q) &&
    $stable(illum_q) && coefficient_value == 32'h0) else $error("control changed while pipeline off");

  // custom coefficients frozen unless custom illuminant
  custom_guard_a: assert property (illum_q != ILL_CUSTOM |=> $stable(custom_q))
    else $error("custom coefficient written outside custom mode");

  // preset loads balance ratios
  wb_preset_load_a: assert property (image_pipeline_enable && preset_wr && !wb_red_wr &&
    illuminant_preset_select == ILL_INCANDESCENT |=> wb_red_q == WB_RED_BASE - WB_STEP &&
    illum_q == ILL_INCANDESCENT) else $error("preset did not load red ratio");

  // conversion readback shows gain in use
  yuv_readback_a: assert property ((image_pipeline_enable && sel_yuv &&
    coefficient_index_select == 4'h0)[*2] |-> coefficient_value == pcmt_fix_to_float(YUV_GAINS[COEF_W-1:0]))
    else $error("conversion readback wrong");

  // disabled correction passes through
  ccm_bypass_a: assert property (pix_valid && !rgb_on_q |=> ccm_valid && ccm_r == $past(pix_r) &&
    ccm_b == $past(pix_b)) else $error("disabled correction altered pixel");

  // disabled vividness passes through
  vivid_bypass_a: assert property (ccm_valid && !vividness_adjust_on |=> lin_valid &&
    lin_g == $past(ccm_g)) else $error("disabled vividness altered pixel");

  // conversion off for rgb formats
  yuv_bypass_a: assert property (gam_valid && !yuv_format_active |=> out_valid &&
    out_c1 == $past(gam_g) && out_c2 == $past(gam_b)) else $error("conversion active without yuv format");

  // pixels reach the gamma stage two cycles after entry
  lin_latency_a: assert property (lin_valid == $past(pix_valid, 2))
    else $error("linear pixel latency wrong");

  // conversion output follows gamma input by one cycle
  out_latency_a: assert property (out_valid == $past(gam_valid))
    else $error("final pixel latency wrong");

  // general preset is the identity matrix
  general_identity_a: assert property (pix_valid && rgb_on_q && illum_q == ILL_GENERAL |=>
    ccm_r == $past(pix_r) && ccm_g == $past(pix_g) && ccm_b == $past(pix_b)) else $error("general set altered pixel");

  // accepted custom write lands in the addressed entry
  custom_write_a: assert property (image_pipeline_enable && coefficient_wr && !sel_yuv && idx_ok &&
    illum_q == ILL_CUSTOM |=> custom_q[$past(coefficient_index_select)] == pcmt_float_to_fix($past(coefficient_wdata)))
    else $error("custom coefficient write lost");

  // coefficient writes aimed at the conversion are ignored
  yuv_coef_ro_a: assert property (coefficient_wr && sel_yuv |=> $stable(custom_q))
    else $error("conversion select changed custom coefficients");

  // unmapped index neither writes nor reads
  bad_index_wr_a: assert property (coefficient_wr && !idx_ok |=> $stable(custom_q))
    else $error("unmapped index changed custom coefficients");

  // unmapped index reads zero
  bad_index_rd_a: assert property (!idx_ok |=> coefficient_value == 32'h0)
    else $error("unmapped index read not zero");

  // conversion enable reflects the pixel format
  yuv_on_read_a: assert property (image_pipeline_enable && sel_yuv |=> transform_instance_on ==
    $past(yuv_format_active)) else $error("conversion enable does not show format state");

  // enable readback is low while the pipeline is off
  off_on_read_a: assert property (!image_pipeline_enable |=> !transform_instance_on)
    else $error("enable readback high while pipeline off");

  // custom choice keeps the balance ratios
  custom_keeps_wb_a: assert property (image_pipeline_enable && preset_wr && !wb_red_wr && !wb_blue_wr &&
    illuminant_preset_select == ILL_CUSTOM |=> $stable(wb_red_q) && $stable(wb_blue_q)) else $error("custom changed ratios");

  // manual red ratio write always lands
  red_manual_a: assert property (wb_red_wr |=> white_balance_red_ratio == $past(wb_ratio_wdata))
    else $error("manual red ratio lost");

  // manual blue ratio write always lands
  blue_manual_a: assert property (wb_blue_wr |=> white_balance_blue_ratio == $past(wb_ratio_wdata))
    else $error("manual blue ratio lost");

  // accepted preset write becomes the current choice
  preset_set_a: assert property (image_pipeline_enable && preset_wr |=>
    illuminant_preset == $past(illuminant_preset_select)) else $error("preset write lost");

  // a grey pixel keeps its value through vividness adjust
  vivid_grey_a: assert property (ccm_valid && ccm_r == ccm_g && ccm_g == ccm_b |=>
    lin_r == $past(ccm_r) && lin_b == $past(ccm_b)) else $error("vividness altered grey pixel");
endmodule : pcmt_top

// ==== verification/pcmt_gamma_model.sv ====
`timescale 1ns/1ps
// stand-in gamma stage: halves each channel, answers on the falling edge after lin_valid
module pcmt_gamma_model #(
  parameter int PIX_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // linear pixels in
  input wire logic lin_valid,
  input wire logic [PIX_W-1:0] lin_r,
  input wire logic [PIX_W-1:0] lin_g,
  input wire logic [PIX_W-1:0] lin_b,
  // curved pixels out
  output logic gam_valid,
  output logic [PIX_W-1:0] gam_r,
  output logic [PIX_W-1:0] gam_g,
  output logic [PIX_W-1:0] gam_b
);
  // idle data shows the inverse of its last value so stale data never matches
  always @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gam_valid <= 1'b0;
      gam_r <= '0;
      gam_g <= '0;
      gam_b <= '0;
    end else if (lin_valid) begin
      gam_valid <= 1'b1;
      gam_r <= lin_r >> 1;
      gam_g <= lin_g >> 1;
      gam_b <= lin_b >> 1;
    end else begin
      gam_valid <= 1'b0;
      gam_r <= ~gam_r;
      gam_g <= ~gam_g;
      gam_b <= ~gam_b;
    end
  end
endmodule : pcmt_gamma_model

// ==== verification/pcmt_top_tb.sv ====
`timescale 1ns/1ps
// self-checking bench for the colour transform path
module pcmt_top_tb import pcmt_pkg::*;;
  logic clk, rst_n, pix_valid, lin_valid, gam_valid, out_valid;
  logic [11:0] pix_r, pix_g, pix_b, lin_r, lin_g, lin_b, gam_r, gam_g, gam_b, out_c0, out_c1, out_c2;
  logic ipe, yuv, sel, on_wr, on_wd, on_q, c_wr, p_wr, wr_r, wr_b, viv_on;
  logic [3:0] idx;
  logic [31:0] c_wd, c_val;
  logic [2:0] p_sel, p_cur;
  logic [15:0] wb_wd, wb_red, wb_blue;
  logic [11:0] viv_lvl;
  int miscompares = 0;
  int compares = 0;

  pcmt_top uut (.clk(clk), .rst_n(rst_n), .pix_valid(pix_valid), .pix_r(pix_r), .pix_g(pix_g), .pix_b(pix_b),
    .lin_valid(lin_valid), .lin_r(lin_r), .lin_g(lin_g), .lin_b(lin_b), .gam_valid(gam_valid), .gam_r(gam_r),
    .gam_g(gam_g), .gam_b(gam_b), .out_valid(out_valid), .out_c0(out_c0), .out_c1(out_c1), .out_c2(out_c2),
    .image_pipeline_enable(ipe), .yuv_format_active(yuv), .transform_instance_select(sel),
    .transform_on_wr(on_wr), .transform_on_wdata(on_wd), .transform_instance_on(on_q),
    .coefficient_index_select(idx), .coefficient_wr(c_wr), .coefficient_wdata(c_wd), .coefficient_value(c_val),
    .preset_wr(p_wr), .illuminant_preset_select(p_sel), .illuminant_preset(p_cur), .wb_red_wr(wr_r),
    .wb_blue_wr(wr_b), .wb_ratio_wdata(wb_wd), .white_balance_red_ratio(wb_red),
    .white_balance_blue_ratio(wb_blue), .vividness_adjust_on(viv_on), .vividness_level(viv_lvl));

  pcmt_gamma_model gam (.clk(clk), .rst_n(rst_n), .lin_valid(lin_valid), .lin_r(lin_r), .lin_g(lin_g),
    .lin_b(lin_b), .gam_valid(gam_valid), .gam_r(gam_r), .gam_g(gam_g), .gam_b(gam_b));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [35:0] ex, input logic [35:0] sn);
    compares++;
    if (sn !== ex) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, ex, sn);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // control strobes are one cycle long; readback settles two edges later
  task automatic wr_coef(input logic [3:0] i, input logic [31:0] d);
    idx = i;
    c_wd = d;
    c_wr = 1'b1;
    tick(1);
    c_wr = 1'b0;
    tick(2);
  endtask : wr_coef

  task automatic wr_preset(input logic [2:0] p);
    p_sel = p;
    p_wr = 1'b1;
    tick(1);
    p_wr = 1'b0;
    tick(2);
  endtask : wr_preset

  task automatic wr_on(input logic v);
    on_wd = v;
    on_wr = 1'b1;
    tick(1);
    on_wr = 1'b0;
    tick(2);
  endtask : wr_on

  task automatic rd_coef(input logic [3:0] i, input logic [31:0] ex);
    idx = i;
    tick(2);
    chk("coefficient_value", ex, c_val);
  endtask : rd_coef

  // one pixel through correction, gamma stand-in and final transform
  task automatic pix(input logic [11:0] r, g, b, lr, lg, lb, o0, o1, o2);
    pix_r = r;
    pix_g = g;
    pix_b = b;
    pix_valid = 1'b1;
    tick(1);
    pix_valid = 1'b0;
    pix_r = ~r;
    pix_g = ~g;
    pix_b = ~b;
    tick(1);
    chk("lin_valid", 1, lin_valid);
    chk("lin", {lr, lg, lb}, {lin_r, lin_g, lin_b});
    tick(1);
    chk("out_valid", 1, out_valid);
    chk("out", {o0, o1, o2}, {out_c0, out_c1, out_c2});
  endtask : pix

  task automatic t_reset();
    chk("red ratio", 16'h1000, wb_red);
    chk("blue ratio", 16'h1000, wb_blue);
    chk("preset", 0, p_cur);
    chk("transform on", 1, on_q);
    rd_coef(4'h0, 32'h3f800000);
    rd_coef(4'h1, 32'h00000000);
    pix(12'h123, 12'h456, 12'h789, 12'h123, 12'h456, 12'h789, 12'h091, 12'h22b, 12'h3c4);
  endtask : t_reset

  task automatic t_preset();
    wr_preset(3'h1);
    chk("preset", 1, p_cur);
    chk("red ratio", 16'h1b00, wb_red);
    chk("blue ratio", 16'h1300, wb_blue);
    rd_coef(4'h0, 32'h3f860000);
    rd_coef(4'h1, 32'hbcc00000);
    pix(12'h800, 12'h400, 12'h400, 12'h830, 12'h3e8, 12'h3e8, 12'h418, 12'h1f4, 12'h1f4);
    for (int p = 0; p < 7; p++) begin
      wr_preset(3'(p));
      chk("red ratio", 16'h1c00 - 16'(p) * 16'h0100, wb_red);
      chk("blue ratio", 16'h1200 + 16'(p) * 16'h0100, wb_blue);
    end
    wb_wd = 16'h1234;
    wr_r = 1'b1;
    tick(1);
    wr_r = 1'b0;
    tick(2);
    chk("red ratio", 16'h1234, wb_red);
    chk("blue ratio", 16'h1800, wb_blue);
  endtask : t_preset

  task automatic t_custom();
    wr_coef(4'h0, 32'h40000000);
    rd_coef(4'h0, 32'h3fa40000);
    wr_preset(3'h7);
    chk("red ratio", 16'h1234, wb_red);
    wr_coef(4'h0, 32'h40000000);
    wr_coef(4'h9, 32'h41200000);
    wr_coef(4'hc, 32'h40000000);
    rd_coef(4'h0, 32'h40000000);
    rd_coef(4'h9, 32'h41200000);
    rd_coef(4'hc, 32'h00000000);
    pix(12'h100, 12'h050, 12'h060, 12'h20a, 12'h050, 12'h060, 12'h105, 12'h028, 12'h030);
    pix(12'hff0, 12'h050, 12'h060, 12'hfff, 12'h050, 12'h060, 12'h7ff, 12'h028, 12'h030);
  endtask : t_custom

  task automatic t_enable();
    wr_on(1'b0);
    chk("transform on", 0, on_q);
    pix(12'h100, 12'h050, 12'h060, 12'h100, 12'h050, 12'h060, 12'h080, 12'h028, 12'h030);
    wr_on(1'b1);
    chk("transform on", 1, on_q);
    wr_on(1'b0);
  endtask : t_enable

  task automatic t_yuv();
    sel = 1'b1;
    tick(2);
    chk("transform on", 0, on_q);
    wr_on(1'b1);
    chk("transform on", 0, on_q);
    yuv = 1'b1;
    tick(2);
    chk("transform on", 1, on_q);
    rd_coef(4'h0, 32'h3e992000);
    wr_coef(4'h0, 32'h40000000);
    rd_coef(4'h0, 32'h3e992000);
    pix(12'h600, 12'h600, 12'h600, 12'h600, 12'h600, 12'h600, 12'h300, 12'h800, 12'h800);
    yuv = 1'b0;
    sel = 1'b0;
    tick(2);
    chk("transform on", 0, on_q);
  endtask : t_yuv

  task automatic t_vivid();
    viv_lvl = 12'h200;
    pix(12'h400, 12'h200, 12'h200, 12'h400, 12'h200, 12'h200, 12'h200, 12'h100, 12'h100);
    viv_on = 1'b1;
    tick(1);
    pix(12'h400, 12'h200, 12'h200, 12'h580, 12'h180, 12'h180, 12'h2c0, 12'h0c0, 12'h0c0);
    viv_on = 1'b0;
  endtask : t_vivid

  task automatic t_gate();
    ipe = 1'b0;
    tick(2);
    chk("transform on", 0, on_q);
    chk("coefficient_value", 0, c_val);
    wr_preset(3'h3);
    wb_wd = 16'h0abc;
    wr_b = 1'b1;
    tick(1);
    wr_b = 1'b0;
    tick(2);
    chk("blue ratio", 16'h0abc, wb_blue);
    chk("red ratio", 16'h1234, wb_red);
    ipe = 1'b1;
    tick(2);
    chk("preset", 7, p_cur);
  endtask : t_gate

  // main sequence
  initial begin
    {pix_valid, on_wr, on_wd, c_wr, p_wr, wr_r, wr_b, viv_on, yuv, sel} = '0;
    {pix_r, pix_g, pix_b, idx, c_wd, p_sel, wb_wd} = '0;
    viv_lvl = 12'h100;
    ipe = 1'b1;
    rst_n = 1'b0;
    tick(6);
    rst_n = 1'b1;
    tick(3);
    t_reset();
    t_preset();
    t_custom();
    t_enable();
    t_yuv();
    t_vivid();
    t_gate();
    give_verdict();
  end

  // watchdog, well beyond the roughly 130 cycles the tests take
  initial begin
    #2000000;
    miscompares++;
    give_verdict();
  end
endmodule : pcmt_top_tb
